// ### swdrg_cpu_model.sv
// Host processor model: toggles the watchdog kick while it runs.
// Assumes it is quiet while the supervisor holds it in reset.
`timescale 1ns/100ps
module swdrg_cpu_model (
    // Clock and the supervisor's reset.
    input  wire       clk_sys_i,
    input  wire       reset_n_i,
    // Mode 0 static, 1 kicking, 2 pin open; toggle spacing.
    input  wire [1:0] mode_i,
    input  wire [7:0] gap_i,
    // Decoded kick level.
    output wire [1:0] kick_o
);
    reg       lvl_q = 1'b0;
    reg [7:0] cnt_q = 8'h00;
    // Toggle the kick every gap cycles in mode 1 while out of reset.
    always @(posedge clk_sys_i) begin
        if (reset_n_i && mode_i == 2'h1 && cnt_q + 8'h01 >= gap_i) begin
            lvl_q <= ~lvl_q;
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    assign kick_o = (mode_i == 2'h2) ? 2'h2 : {1'b0, lvl_q};
endmodule

// ### swdrg_defines.vh
// Constants for the supervisor, watchdog and reset gate block.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef SWDRG_DEFINES_VH
`define SWDRG_DEFINES_VH

// ============================================================
// System clock.
`define SWDRG_CLK_HZ          10000000
// ============================================================
// Internal oscillator period in ns (arbitrary plain rate, 1 kHz tick).
`define SWDRG_INT_TICK_NS     1000000
`define SWDRG_INT_TICK_CYC    (`SWDRG_INT_TICK_NS / 100)
// Internal periods in ms.
`define SWDRG_WD_FAST_MS      100
`define SWDRG_WD_SLOW_MS      1600
`define SWDRG_RST_MS          200
// Internal periods as tick counts of the 1 kHz timebase (100, 1600 and
// 200 ticks), sized to the 13-bit period counters.
`define SWDRG_WD_FAST_TK      13'h0064
`define SWDRG_WD_SLOW_TK      13'h0640
`define SWDRG_RST_TK          13'h00C8
// External timebase periods in clock cycles of the timing input
// (1024, 4096 and 2048 cycles), sized to the period counters.
`define SWDRG_EXT_WD_NORM     13'h0400
`define SWDRG_EXT_WD_LONG     13'h1000
`define SWDRG_EXT_RST         13'h0800
// ============================================================
// Chip-enable hold window after reset asserts, in ns and cycles.
`define SWDRG_CE_HOLD_NS      15000
`define SWDRG_CE_HOLD_CYC     (`SWDRG_CE_HOLD_NS / 100)
// Least kick pulse in ns and cycles (rounded up, at least one).
`define SWDRG_KICK_MIN_NS     100
`define SWDRG_KICK_MIN_CYC    ((`SWDRG_KICK_MIN_NS + 99) / 100)
// ============================================================
// Kick input level codes.
`define SWDRG_KICK_LOW        2'h0
`define SWDRG_KICK_HIGH       2'h1
`define SWDRG_KICK_FLOAT      2'h2
// Watchdog states.
`define SWDRG_ST_OFF          2'h0
`define SWDRG_ST_RUN          2'h1
`define SWDRG_ST_RST          2'h2

`endif

// ### swdrg_tick_gen.v
// Timebase tick generator: one-cycle pulse per timebase period.
// Assumes the timing input is already synchronous to clk_sys_i.
`timescale 1ns/100ps
module swdrg_tick_gen #(
    parameter INT_DIV = 32'h0000_2710
) (
    // Clock and reset.
    input  wire clk_sys_i,
    input  wire reset_n_i,
    // Timebase selection.
    input  wire timebase_select_i,
    input  wire timing_input_i,
    // Tick out.
    output reg  tick_o
);
    reg [31:0] div_q;
    reg        tin_q;

    // ==========================================================
    // Internal divider or rising edge of the external timing input.
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div_q  <= 32'h0000_0000;
            tin_q  <= 1'b0;
            tick_o <= 1'b0;
        end else begin
            tin_q <= timing_input_i;
            if (timebase_select_i) begin
                // Internal oscillator drives the timebase.
                if (div_q >= INT_DIV - 1) begin
                    div_q  <= 32'h0000_0000;
                    tick_o <= 1'b1;
                end else begin
                    div_q  <= div_q + 32'h0000_0001;
                    tick_o <= 1'b0;
                end
            end else begin
                // External capacitor or clock: one tick per rise.
                div_q  <= 32'h0000_0000;
                tick_o <= timing_input_i & ~tin_q;
            end
        end
    end
endmodule

// ### swdrg_top.v
// Supervisor top: supply switchover, low-line, power-fail, watchdog,
// reset stretch and chip-enable gating for battery-backed memory.
// Assumes all comparator results and the decoded kick level arrive
// already synchronised to clk_sys_i.
//
// Behaviour
// - Rail uses battery only when supply is below both threshold and battery, else main supply.
// - Battery flag high on battery rail, low on main rail.
// - Low-line flag follows the threshold comparator, no timeout.
// - Select high: internal timebase, timing input picks fast or slow.
// - Select low: timing input clock is the timebase.
// - Power-fail flag low when sense below 1.25V, affects nothing else.
// - Floating kick level disables the watchdog entirely.
// - Static kick past timeout: fault low and reset for reset period.
// - Fault stays low until the next kick transition, a floating kick, low supply or the battery rail.
// - Fault output high while kick floats.
// - Gated enable low only if enable low and reset released, or within the hold window.
// - Enable held at reset for 15us or until input rises.
// - Reset low below threshold and 200ms after recovery.
// - Active-high reset is inverse, open-drain style.
// - Any kick change or 100ns pulse restarts the watchdog.
// - Watchdog off, fault high, while supply low or on battery.
// - Fast internal: 100ms normal, 1.6s after reset, 200ms reset.
// - Static kick repeats 200ms reset pulses every 1.6s.
`timescale 1ns/100ps
`include "swdrg_defines.vh"
module swdrg_top #(
    parameter INT_DIV = `SWDRG_INT_TICK_CYC,
    parameter CE_HOLD = `SWDRG_CE_HOLD_CYC
) (
    // Clock and reset.
    input  wire       clk_sys_i,
    input  wire       reset_n_i,
    // Comparator results, synchronous.
    input  wire       supply_low_i,
    input  wire       supply_below_cell_i,
    input  wire       power_fail_sense_low_i,
    // Kick level and timebase pins.
    input  wire [1:0] watchdog_kick_i,
    input  wire       timebase_select_i,
    input  wire       timing_input_i,
    // Memory enable input, active low.
    input  wire       mem_enable_n_i,
    // Status outputs.
    output reg        rail_on_cell_o,
    output reg        battery_active_flag_o,
    output reg        low_line_n_o,
    output reg        power_fail_flag_n_o,
    output reg        watchdog_fault_n_o,
    // Reset outputs.
    output reg        reset_n_o,
    output reg        reset_hi_o,
    output reg        reset_hi_oe_o,
    // Gated memory enable, active low.
    output reg        mem_enable_n_o
);
    // Machine states: reset stretch and watchdog run.
    localparam [1:0] ST_RUN = 2'h1;
    localparam [1:0] ST_RST = 2'h2;

    wire        tick;
    reg  [1:0]  st_q;
    reg  [1:0]  kick_q;
    reg  [12:0] wd_cnt_q;
    reg  [12:0] rst_cnt_q;
    reg         long_q;
    reg         rst_act_q;
    reg  [31:0] ce_cnt_q;
    reg         ce_pass_q;
    reg  [12:0] wd_lim_d;
    reg  [12:0] rst_lim_d;
    wire        kick_float;
    wire        kick_edge;
    wire        wd_block;
    wire        rst_d;

    // ==========================================================
    // Timebase ticks.
    swdrg_tick_gen #(
        .INT_DIV           (INT_DIV)
    ) u_tick (
        .clk_sys_i         (clk_sys_i),
        .reset_n_i         (reset_n_i),
        .timebase_select_i (timebase_select_i),
        .timing_input_i    (timing_input_i),
        .tick_o            (tick)
    );

    // Kick decoding and restart events.
    assign kick_float = (watchdog_kick_i == `SWDRG_KICK_FLOAT);
    assign kick_edge  = (watchdog_kick_i != kick_q);
    assign wd_block   = supply_low_i | rail_on_cell_o | kick_float;

    // ==========================================================
    // Period limits for the selected timebase.
    always @* begin
        if (timebase_select_i) begin
            rst_lim_d = `SWDRG_RST_TK;
            if (!timing_input_i && !long_q)
                wd_lim_d = `SWDRG_WD_FAST_TK;
            else
                wd_lim_d = `SWDRG_WD_SLOW_TK;
        end else begin
            rst_lim_d = `SWDRG_EXT_RST;
            if (long_q)
                wd_lim_d = `SWDRG_EXT_WD_LONG;
            else
                wd_lim_d = `SWDRG_EXT_WD_NORM;
        end
    end

    // ==========================================================
    // Watchdog and reset stretch machine.
    // Restarting on any level change also covers short kick pulses,
    // since a pulse is two level changes a few cycles apart; a pulse
    // shorter than one clock cycle is seen only if it spans a rising clock edge.
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q               <= ST_RST;
            kick_q             <= `SWDRG_KICK_FLOAT;
            wd_cnt_q           <= 13'h0000;
            rst_cnt_q          <= 13'h0000;
            long_q             <= 1'b1;
            watchdog_fault_n_o <= 1'b1;
        end else begin
            kick_q <= watchdog_kick_i;
            if (kick_edge || wd_block)
                watchdog_fault_n_o <= 1'b1;
            if (supply_low_i) begin
                // Hold reset while the supply is low.
                st_q      <= ST_RST;
                rst_cnt_q <= 13'h0000;
                long_q    <= 1'b1;
            end else begin
                case (st_q)
                ST_RST: begin
                    wd_cnt_q <= 13'h0000;
                    if (tick)
                        rst_cnt_q <= rst_cnt_q + 13'h0001;
                    if (tick && rst_cnt_q >= rst_lim_d - 13'h0001) begin
                        st_q      <= ST_RUN;
                        rst_cnt_q <= 13'h0000;
                        long_q    <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (wd_block) begin
                        wd_cnt_q <= 13'h0000;
                    end else if (kick_edge) begin
                        wd_cnt_q <= 13'h0000;
                        long_q   <= 1'b0;
                    end else if (tick) begin
                        if (wd_cnt_q >= wd_lim_d - 13'h0001) begin
                            watchdog_fault_n_o <= 1'b0;
                            st_q               <= ST_RST;
                            wd_cnt_q           <= 13'h0000;
                        end else begin
                            wd_cnt_q <= wd_cnt_q + 13'h0001;
                        end
                    end
                end
                default: begin
                    st_q <= ST_RST;
                end
                endcase
            end
        end
    end

    // Reset request: low supply or any state but run.
    assign rst_d = supply_low_i | (st_q != ST_RUN);

    // ==========================================================
    // Chip-enable hold window after reset asserts.
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_act_q <= 1'b1;
            ce_cnt_q  <= 32'h0000_0000;
            ce_pass_q <= 1'b0;
        end else begin
            rst_act_q <= rst_d;
            if (!rst_d) begin
                ce_pass_q <= 1'b1;
                ce_cnt_q  <= 32'h0000_0000;
            end else if (!rst_act_q) begin
                // Reset just asserted: keep passing only if enable low.
                ce_pass_q <= ~mem_enable_n_i;
                ce_cnt_q  <= 32'h0000_0000;
            end else if (ce_pass_q) begin
                ce_cnt_q <= ce_cnt_q + 32'h0000_0001;
                if (mem_enable_n_i || ce_cnt_q >= CE_HOLD - 1)
                    ce_pass_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Registered outputs.
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rail_on_cell_o        <= 1'b0;
            battery_active_flag_o <= 1'b0;
            low_line_n_o          <= 1'b0;
            power_fail_flag_n_o   <= 1'b0;
            reset_n_o             <= 1'b0;
            reset_hi_o            <= 1'b0;
            reset_hi_oe_o         <= 1'b0;
            mem_enable_n_o        <= 1'b1;
        end else begin
            // Comparator levels arrive synchronised and are used as is.
            rail_on_cell_o <= supply_low_i & supply_below_cell_i;
            battery_active_flag_o <= supply_low_i & supply_below_cell_i;
            low_line_n_o        <= ~supply_low_i;
            power_fail_flag_n_o <= ~power_fail_sense_low_i;
            reset_n_o           <= ~rst_d;
            // Open drain: never drives high, pin level set by pull.
            reset_hi_o          <= 1'b0;
            reset_hi_oe_o       <= ~rst_d;
            mem_enable_n_o <= ~(~mem_enable_n_i &
                              (~rst_d | ce_pass_q));
        end
    end
endmodule

// ### swdrg_top_assertions.sv
// Port checker for the supervisor top, bound to every instance.
// Assumes one clock and the top's asynchronous active-low reset.
`timescale 1ns/100ps
module swdrg_top_checker #(
    parameter CE_HOLD = 150
) (
    input wire       clk_sys_i,
    input wire       reset_n_i,
    input wire       supply_low_i,
    input wire       supply_below_cell_i,
    input wire       power_fail_sense_low_i,
    input wire [1:0] watchdog_kick_i,
    input wire       mem_enable_n_i,
    input wire       rail_on_cell_o,
    input wire       battery_active_flag_o,
    input wire       low_line_n_o,
    input wire       power_fail_flag_n_o,
    input wire       watchdog_fault_n_o,
    input wire       reset_n_o,
    input wire       reset_hi_o,
    input wire       reset_hi_oe_o,
    input wire       mem_enable_n_o
);
    int hold_q;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    // Counts cycles the gated enable stays low while reset is asserted.
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i)
            hold_q <= 0;
        else
            hold_q <= (!reset_n_o && !mem_enable_n_o) ? hold_q + 1 : 0;
    end
    AST_RAIL: assert property ($past(reset_n_i) |->
        rail_on_cell_o == $past(supply_low_i & supply_below_cell_i))
        else $error("rail source does not follow the supplies");
    AST_BATT: assert property (
        battery_active_flag_o == rail_on_cell_o)
        else $error("battery flag differs from rail source");
    AST_LOWLINE: assert property ($past(reset_n_i) |->
        low_line_n_o == !$past(supply_low_i))
        else $error("low-line flag lags or is inverted");
    AST_PFAIL: assert property ($past(reset_n_i) |->
        power_fail_flag_n_o == !$past(power_fail_sense_low_i))
        else $error("power-fail flag does not follow its sense");
    AST_RSTHI: assert property (
        reset_hi_oe_o == reset_n_o && !reset_hi_o)
        else $error("open-drain reset is not the inverse");
    AST_SUPRST: assert property (
        supply_low_i |=> !reset_n_o)
        else $error("reset released with supply low");
    AST_WDOFF: assert property (
        (watchdog_kick_i == 2'h2 || supply_low_i) |=> watchdog_fault_n_o)
        else $error("fault low while watchdog disabled");
    AST_CEHOLD: assert property (
        hold_q <= CE_HOLD + 2)
        else $error("gated enable held too long in reset");
    AST_CEGATE: assert property (
        mem_enable_n_i |=> mem_enable_n_o)
        else $error("gated enable low while its input is high");
endmodule
bind swdrg_top swdrg_top_checker #(.CE_HOLD(CE_HOLD)) u_chk (.*);

// ### swdrg_top_tb.sv
// Self-checking bench for the supervisor top.
// Assumes the bound checker and the host model beside it.
`timescale 1ns/100ps
module swdrg_top_tb;
    logic clk_sys_i = 0, reset_n_i = 0, supply_low_i = 0;
    logic supply_below_cell_i = 0, power_fail_sense_low_i = 0;
    logic timebase_select_i = 1, timing_input_i = 0, mem_enable_n_i = 0;
    logic [1:0] watchdog_kick_i, mode = 2;
    logic rail_on_cell_o, battery_active_flag_o, low_line_n_o;
    logic power_fail_flag_n_o, watchdog_fault_n_o, reset_n_o;
    logic reset_hi_o, reset_hi_oe_o, mem_enable_n_o, slow = 0, ext = 0;
    logic [7:0] gap = 8;
    logic [31:0] seed = 31700;
    int fail_count = 0, total_checks = 0, n;
    swdrg_top #(.INT_DIV(4), .CE_HOLD(20)) DUT (.*);
    swdrg_cpu_model CPU (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_o),
        .mode_i(mode), .gap_i(gap), .kick_o(watchdog_kick_i));
    always #50 clk_sys_i = ~clk_sys_i;
    // Timing input is a clock in external mode, else the speed select.
    always @(posedge clk_sys_i) timing_input_i <= ext ? ~timing_input_i : slow;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    // Expected rail, battery flag, low-line and power-fail levels.
    function automatic logic [3:0] flags(input logic l, b, p);
        return {l & b, l & b, ~l, ~p};
    endfunction
    task automatic check(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask
    // Cycles until output w reaches v, checked against a window.
    task automatic meas(input int w, input logic v, input int a, b);
        for (n = 0; n < 9000 && (w == 0 ? watchdog_fault_n_o : w == 1 ?
             reset_n_o : mem_enable_n_o) !== v; n++) cyc(1);
        check(n >= a && n <= b, 1);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence.
    initial begin
        cyc(10);
        @(posedge clk_sys_i) reset_n_i <= 1;
        cyc(400);
        check(mem_enable_n_o, 1);
        meas(1, 1, 390, 410);
        check({reset_hi_oe_o, reset_hi_o}, 2'h2);
        cyc(2);
        check(mem_enable_n_o, 0);
        @(posedge clk_sys_i) supply_low_i <= 1;
        meas(2, 1, 19, 24);
        @(posedge clk_sys_i) supply_low_i <= 0;
        meas(1, 1, 790, 812);
        @(posedge clk_sys_i) supply_low_i <= 1;
        cyc(5);
        @(posedge clk_sys_i) mem_enable_n_i <= 1;
        cyc(2);
        check(mem_enable_n_o, 1);
        repeat (40) begin
            seed = xs(seed);
            @(posedge clk_sys_i);
            {supply_low_i, supply_below_cell_i, power_fail_sense_low_i}
                <= seed[2:0];
            cyc(3);
            check({rail_on_cell_o, battery_active_flag_o, low_line_n_o,
                power_fail_flag_n_o}, flags(supply_low_i, supply_below_cell_i,
                power_fail_sense_low_i));
            if (supply_low_i)
                check({reset_n_o, reset_hi_oe_o}, 2'h0);
            check(watchdog_fault_n_o, 1);
        end
        @(posedge clk_sys_i);
        {supply_low_i, supply_below_cell_i, power_fail_sense_low_i} <= 3'h0;
        meas(1, 1, 790, 812);
        @(posedge clk_sys_i) gap <= seed[5:0] + 8'h01;
        mode <= 1;
        repeat (30) begin
            seed = xs(seed);
            mem_enable_n_i <= seed[9];
            cyc(100);
            check({watchdog_fault_n_o, reset_n_o, mem_enable_n_o},
                {2'h3, mem_enable_n_i});
        end
        gap <= 1;
        cyc(20);
        @(posedge clk_sys_i) mode <= 0;
        meas(0, 0, 392, 410);
        // Reset follows the fault flag by one cycle.
        cyc(1);
        check(reset_n_o, 0);
        meas(1, 1, 790, 810);
        meas(1, 0, 6390, 6410);
        check(watchdog_fault_n_o, 0);
        meas(1, 1, 790, 810);
        @(posedge clk_sys_i) mode <= 1;
        cyc(3);
        check(watchdog_fault_n_o, 1);
        @(posedge clk_sys_i) mode <= 2;
        repeat (70) begin
            cyc(100);
            check({watchdog_fault_n_o, reset_n_o}, 2'h3);
        end
        @(posedge clk_sys_i) slow <= 1;
        mode <= 1;
        cyc(50);
        @(posedge clk_sys_i) mode <= 0;
        meas(0, 0, 6390, 6412);
        cyc(1);
        check(reset_n_o, 0);
        meas(1, 1, 790, 810);
        @(posedge clk_sys_i) mode <= 2;
        ext <= 1;
        timebase_select_i <= 0;
        supply_low_i <= 1;
        cyc(5);
        @(posedge clk_sys_i) supply_low_i <= 0;
        meas(1, 1, 4088, 4112);
        wrap_up;
    end
    // Watchdog against a hung run.
    initial begin
        #6_000_000;
        fail_count++;
        wrap_up;
    end
endmodule
